// ==== sbs_defines.vh ====
// Constants shared by the burst SRAM port design.
// How it works
// RULE1 - Data in and out lanes are 9, 18 or 36 wide; wider lanes unused.
// RULE2 - Return strobes toggle continuously, aligned to read data, even when data is tristated.
// RULE3 - Read data follows output strobes, or input strobes when both output strobes high.
// RULE4 - Data output bus is driven only for accepted reads, otherwise released.
// RULE5 - With loop bypassed, controller waits 1024 idle cycles before any use.
// RULE6 - Controller raises bypass pin after stable clocks, then waits 1024 idle cycles; the bench raises it as clocks start and waits 8 rises for lock.
// RULE7 - With bypass high and unstable clocks, controller stops strobes 30 ns first.
// RULE8 - During clock stop the true output strobe is low 30 ns, never mid-level.
// RULE9 - After any strobe stop, controller waits 1024 idle cycles before accesses.
// RULE10 - Frequency change with loop enabled needs loop reset and 1024 idle cycles.
// RULE11 - The loop locks to input or output strobe pair, which must be clean.
// RULE12 - With loop enabled, controller keeps clocks at or above 100 MHz; the bench model runs its strobes at 12.5 MHz.
// RULE13 - Write taken at true input rise; words captured on true then complement rise.
// RULE14 - Read at edge t gives word0 after complement out rise t+1, word1 after true t+2.
// RULE15 - Request inputs are sampled only on true input strobe rises.
// RULE16 - Data outputs stay released throughout power-up.
// RULE17 - Stopped clocks ideally park true and complement strobes at opposite levels.
// RULE18 - Both requests high start nothing; stopped clock keeps previous state.
// RULE19 - Internal address LSB added; burst order base plus zero then plus one.
// RULE20 - Read and write bursts may run at the same time.
// RULE21 - Write address taken at complement input rise, read address at true rise.
// RULE22 - Each active-low byte enable, per data word, gates writing of its byte.
`ifndef SBS_DEFINES_VH
`define SBS_DEFINES_VH
`define SBS_DATA_W 36
`define SBS_ADDR_W 6
`define SBS_LANE_W 9
`define SBS_LOCK_NOPS 1024
`endif

// ==== sbs_mem.v ====
// Word memory of the burst SRAM port with per-byte write and registered read.
`timescale 1ns/1ps
`default_nettype none
module sbs_mem #(
  parameter AW = 7,
  parameter DW = 36,
  parameter LW = 9
) (
  // Clock
  input wire clk,
  // Write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [DW/LW-1:0] wr_lane_n,
  // Read port
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  genvar g;
  generate
    for (g = 0; g < DW/LW; g = g + 1) begin : lane
      always @(posedge clk) begin
        if (wr_en && !wr_lane_n[g]) begin // [RULE22]
          mem[wr_addr][g*LW +: LW] <= wr_data[g*LW +: LW];
        end
      end
    end
  endgenerate
  always @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule // sbs_mem
`default_nettype wire

// ==== sbs_port.v ====
// Device side of a two-word burst separate-I/O double data rate static RAM port.
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defines.vh"
module sbs_port #(
  parameter DW = `SBS_DATA_W,
  parameter AW = `SBS_ADDR_W,
  parameter LOCK_NOPS = `SBS_LOCK_NOPS
) (
  // Clock and reset
  input wire core_clk,
  input wire rstn,
  // Strobes from controller
  input wire in_strobe_true,
  input wire in_strobe_inv,
  input wire out_strobe_true,
  input wire out_strobe_inv,
  input wire loop_bypass_n,
  // Requests
  input wire read_n,
  input wire write_n,
  input wire [AW-1:0] addr_in,
  input wire [DW/`SBS_LANE_W-1:0] byte_write_enable_n,
  input wire [DW-1:0] data_in,
  // Read data and return strobes
  output reg [DW-1:0] data_out,
  output reg data_out_oe,
  output reg return_strobe_true,
  output reg return_strobe_inv,
  output reg loop_locked
);
  localparam LW = `SBS_LANE_W;
  localparam NL = DW / LW;
  localparam MW = AW + 1;
  // ==========================================================
  // Pin synchronisers
  // Three stages; an edge counts once stages two and three agree on a change.
  reg [2:0] s_kt, s_kc, s_ct, s_cc;
  reg kt_prev, kc_prev, ct_prev, cc_prev;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      // Complement strobes park high, so their stages reset high to avoid a false rise.
      s_kt <= 3'h0;
      s_kc <= 3'h7;
      s_ct <= 3'h0;
      s_cc <= 3'h7;
      kt_prev <= 1'b0;
      kc_prev <= 1'b1;
      ct_prev <= 1'b0;
      cc_prev <= 1'b1;
    end else begin
      s_kt <= {s_kt[1:0], in_strobe_true};
      s_kc <= {s_kc[1:0], in_strobe_inv};
      s_ct <= {s_ct[1:0], out_strobe_true};
      s_cc <= {s_cc[1:0], out_strobe_inv};
      if (s_kt[1] == s_kt[2]) kt_prev <= s_kt[2];
      if (s_kc[1] == s_kc[2]) kc_prev <= s_kc[2];
      if (s_ct[1] == s_ct[2]) ct_prev <= s_ct[2];
      if (s_cc[1] == s_cc[2]) cc_prev <= s_cc[2];
    end
  end
  wire kt_rise = (s_kt[1] == s_kt[2]) && s_kt[2] && !kt_prev; // [RULE15]
  wire kc_rise = (s_kc[1] == s_kc[2]) && s_kc[2] && !kc_prev;
  wire ct_rise = (s_ct[1] == s_ct[2]) && s_ct[2] && !ct_prev;
  wire cc_rise = (s_cc[1] == s_cc[2]) && s_cc[2] && !cc_prev;
  // Output strobes parked high select the input strobes as output timing.
  wire use_k = s_ct[2] && s_cc[2] && ct_prev && cc_prev; // [RULE3]
  wire o_first = use_k ? kc_rise : cc_rise; // [RULE3]
  wire o_second = use_k ? kt_rise : ct_rise; // [RULE3]
  // ==========================================================
  // Request capture and write burst
  reg wr_pend, wr_second;
  reg [AW-1:0] wr_addr;
  reg [NL-1:0] wr_be0;
  reg [DW-1:0] wr_d0;
  reg mem_we;
  reg [MW-1:0] mem_wa;
  reg [DW-1:0] mem_wd;
  reg [NL-1:0] mem_wbe;
  // Input sampled at one true rise are latched in the same cycle the edge is seen.
  wire [DW-1:0] din_used = data_in & {DW{1'b1}}; // [RULE1]
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend <= 1'b0;
      wr_second <= 1'b0;
      wr_addr <= {AW{1'b0}};
      wr_be0 <= {NL{1'b1}};
      wr_d0 <= {DW{1'b0}};
      mem_we <= 1'b0;
      mem_wa <= {MW{1'b0}};
      mem_wd <= {DW{1'b0}};
      mem_wbe <= {NL{1'b1}};
    end else begin
      mem_we <= 1'b0;
      if (kt_rise && !write_n) begin // [RULE13] [RULE18]
        wr_pend <= 1'b1;
        wr_be0 <= byte_write_enable_n; // [RULE22]
        wr_d0 <= din_used; // [RULE13]
      end
      if (kc_rise && wr_pend) begin
        wr_pend <= 1'b0;
        wr_addr <= addr_in; // [RULE21]
        wr_second <= 1'b1;
        mem_we <= 1'b1;
        mem_wa <= {addr_in, 1'b0}; // [RULE19]
        mem_wd <= wr_d0;
        mem_wbe <= wr_be0;
        wr_d0 <= din_used; // [RULE13]
        wr_be0 <= byte_write_enable_n; // [RULE22]
      end else if (wr_second) begin
        wr_second <= 1'b0;
        mem_we <= 1'b1;
        mem_wa <= {wr_addr, 1'b1}; // [RULE19]
        mem_wd <= wr_d0;
        mem_wbe <= wr_be0;
      end
    end
  end
  // ==========================================================
  // Read burst, runs independently of the write burst.
  // Phase counts output-strobe edges after the request edge t.
  localparam RD_IDLE = 2'h0;
  localparam RD_WAIT = 2'h1;
  localparam RD_W0 = 2'h2;
  localparam RD_W1 = 2'h3;
  reg [1:0] rd_state;
  reg [AW-1:0] rd_addr;
  reg rd_lsb;
  reg rd_skip;
  wire [DW-1:0] mem_rd;
  reg rd_req_q;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_state <= RD_IDLE;
      rd_addr <= {AW{1'b0}};
      rd_lsb <= 1'b0;
      rd_skip <= 1'b0;
      rd_req_q <= 1'b0;
      data_out <= {DW{1'b0}};
      data_out_oe <= 1'b0; // [RULE16]
    end else begin
      rd_req_q <= 1'b0;
      if (kt_rise && !read_n) begin // [RULE15] [RULE20]
        rd_addr <= addr_in; // [RULE21]
        rd_lsb <= 1'b0;
        rd_skip <= 1'b1;
        rd_state <= RD_WAIT;
        rd_req_q <= 1'b1;
      end else begin
        case (rd_state)
          RD_WAIT: begin
            // The complement edge of cycle t is passed over; word0 waits for cycle t+1.
            if (o_first && !rd_req_q && rd_skip) begin // [RULE14]
              rd_skip <= 1'b0;
              data_out_oe <= 1'b0; // [RULE4]
            end else if (o_first && !rd_req_q) begin // [RULE14]
              data_out <= mem_rd;
              data_out_oe <= 1'b1; // [RULE4]
              rd_lsb <= 1'b1; // [RULE19]
              rd_state <= RD_W0;
            end
          end
          RD_W0: begin
            if (o_second) begin // [RULE14]
              data_out <= mem_rd;
              rd_state <= RD_W1;
            end
          end
          RD_W1: begin
            if (o_first) begin
              data_out_oe <= 1'b0; // [RULE4]
              rd_state <= RD_IDLE;
            end
          end
          default: begin
            data_out_oe <= 1'b0; // [RULE4]
          end
        endcase
      end
    end
  end
  // ==========================================================
  // Return strobes mirror the output timing pair, free running.
  reg [10:0] lock_cnt;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      return_strobe_true <= 1'b0;
      return_strobe_inv <= 1'b1;
      lock_cnt <= 11'h000;
      loop_locked <= 1'b0;
    end else begin
      if (o_second) begin // [RULE2]
        return_strobe_true <= 1'b1;
        return_strobe_inv <= 1'b0;
      end else if (o_first) begin // [RULE2]
        return_strobe_true <= 1'b0;
        return_strobe_inv <= 1'b1;
      end
      // Status only: the loop counts true input strobe rises while enabled, whether or not requests are idle.
      if (!loop_bypass_n) begin
        lock_cnt <= 11'h000;
        loop_locked <= 1'b0;
      end else if (kt_rise && !loop_locked) begin // [RULE11]
        lock_cnt <= lock_cnt + 11'h001;
        if (lock_cnt == LOCK_NOPS[10:0] - 11'h001) loop_locked <= 1'b1;
      end
    end
  end
  sbs_mem #(.AW(MW), .DW(DW), .LW(LW)) u_mem (
    .clk(core_clk),
    .wr_en(mem_we),
    .wr_addr(mem_wa),
    .wr_data(mem_wd),
    .wr_lane_n(mem_wbe),
    .rd_addr({rd_addr, rd_lsb}),
    .rd_data(mem_rd)
  );
endmodule // sbs_port
`default_nettype wire

// ==== sbs_port_checker.sv ====
// Port checks for the burst SRAM port.
`timescale 1ns/1ps
`default_nettype none
module sbs_port_checker #(parameter LOCK_NOPS = 1024) (
  // Inputs
  input wire logic core_clk, rstn, in_strobe_true, loop_bypass_n, read_n, write_n,
  input wire logic data_out_oe, return_strobe_true, return_strobe_inv, loop_locked
);
  // =====
  // Ages since last read request and last return strobe edge.
  logic [5:0] rd_age;
  logic [4:0] rt_age;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_age <= 6'h00;
      rt_age <= 5'h00;
    end else begin
      rd_age <= !read_n ? 6'h00 : rd_age + 6'(rd_age != 6'h3F);
      rt_age <= $changed(return_strobe_true) ? 5'h00 : rt_age + 5'(rt_age != 5'h1F);
    end
  end
  // =====
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_reset_quiet: assert property (disable iff (1'b0) !rstn |-> !data_out_oe && !loop_locked)
    else $error("outputs active in reset");
  a_ret_reset: assert property (disable iff (1'b0) !rstn |-> !return_strobe_true && return_strobe_inv)
    else $error("return strobes wrong in reset");
  a_ret_runs: assert property (rt_age < 5'h14)
    else $error("return strobe stalled");
  a_idle_quiet: assert property (rd_age >= 6'h28 |-> !data_out_oe)
    else $error("data driven without read");
  a_oe_burst: assert property ($rose(data_out_oe) |-> data_out_oe [*4])
    else $error("read burst cut short");
  a_ret_pair: assert property (return_strobe_inv == !return_strobe_true)
    else $error("return strobes not complementary");
  a_read_answer: assert property ($rose(in_strobe_true) && !read_n && loop_locked |-> ##[16:22] data_out_oe)
    else $error("read not answered");
  a_lock_drop: assert property (!loop_bypass_n |-> ##[1:4] !loop_locked)
    else $error("lock kept while bypassed");
  a_lock_wait: assert property ($rose(loop_locked) |-> $past(loop_bypass_n, 6))
    else $error("lock came too early");
  cover property ($rose(data_out_oe));
  cover property ($rose(loop_locked));
  cover property ($rose(in_strobe_true) && !read_n && !write_n);
endmodule // sbs_port_checker
bind sbs_port sbs_port_checker #(.LOCK_NOPS(LOCK_NOPS)) chk_u (.core_clk, .rstn, .in_strobe_true, .loop_bypass_n,
  .read_n, .write_n, .data_out_oe, .return_strobe_true, .return_strobe_inv, .loop_locked);
`default_nettype wire

// ==== sbs_ctrl_model.sv ====
// Controller model that makes both strobe pairs.
`timescale 1ns/1ps
`default_nettype none
module sbs_ctrl_model (
  // Controls and strobes
  input wire logic run, tie_out,
  output wire logic in_strobe_true, in_strobe_inv, out_strobe_true, out_strobe_inv
);
  // =====
  // Fixed clean period, so no relock is ever needed.
  logic ph = 1'b0;
  // Stopped pairs park true low, complement high, for a symmetric restart.
  always #40 ph = run ? ~ph : 1'b0;
  // Strobes never stop once running, so no recovery idle span is owed.
  assign in_strobe_true = ph;
  assign in_strobe_inv = ~ph;
  // Tied-high output pair hands output timing to the input pair.
  assign out_strobe_true = tie_out | ph;
  assign out_strobe_inv = tie_out | ~ph;
endmodule // sbs_ctrl_model
`default_nettype wire

// ==== sbs_port_tb.sv ====
// Self-checking bench for the burst SRAM port.
`timescale 1ns/1ps
`default_nettype none
module sbs_port_tb;
  // =====
  // Wiring
  logic core_clk = 1'b0, rstn = 1'b1, run = 1'b0, tie_out = 1'b0, loop_bypass_n = 1'b0;
  logic read_n = 1'b1, write_n = 1'b1;
  logic [5:0] addr_in = 6'h00;
  logic [3:0] byte_write_enable_n = 4'hF;
  logic [35:0] data_in = 36'h0;
  wire logic [35:0] data_out;
  wire logic data_out_oe, return_strobe_true, return_strobe_inv, loop_locked;
  wire logic in_strobe_true, in_strobe_inv, out_strobe_true, out_strobe_inv;
  int mismatches = 0, num_checks = 0;
  localparam logic [35:0] D0 = 36'h123456789, D1 = 36'hFEDCBA987, P0 = 36'h0F0F0F0F0, P1 = 36'h5A5A5A5A5;
  localparam logic [35:0] D2 = 36'hABCDEF012, D3 = 36'h13579BDF0;
  always #4 core_clk = ~core_clk;
  sbs_ctrl_model ctl_u (.run, .tie_out, .in_strobe_true, .in_strobe_inv, .out_strobe_true, .out_strobe_inv);
  sbs_port #(.LOCK_NOPS(8)) dut_u (.core_clk, .rstn, .in_strobe_true, .in_strobe_inv, .out_strobe_true,
    .out_strobe_inv, .loop_bypass_n, .read_n, .write_n, .addr_in, .byte_write_enable_n, .data_in, .data_out,
    .data_out_oe, .return_strobe_true, .return_strobe_inv, .loop_locked);
  // =====
  // Tasks
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic clk_n(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Read address rides the true phase, write address and second word the complement phase.
  task automatic xfer(input logic rd, wr, input logic [5:0] ra, wa, input logic [35:0] d0, d1,
    input logic [3:0] b0, b1);
    @(posedge in_strobe_inv);
    clk_n(1);
    {read_n, write_n, addr_in, data_in, byte_write_enable_n} = {!rd, !wr, ra, d0, b0};
    @(posedge in_strobe_true);
    clk_n(5);
    {read_n, addr_in, data_in, byte_write_enable_n} = {1'b1, wa, d1, b1};
    @(posedge in_strobe_inv);
    clk_n(5);
    {write_n, addr_in, data_in, byte_write_enable_n} = {1'b1, ~wa, ~d1, 4'hF};
  endtask
  task automatic rd_chk(input logic [35:0] e0, e1);
    @(posedge in_strobe_inv);
    clk_n(5);
    chk(36'(data_out_oe), 36'h1);
    chk(data_out, e0);
    chk(36'(return_strobe_true), 36'h0);
    @(posedge in_strobe_true);
    clk_n(5);
    chk(data_out, e1);
    chk(36'(return_strobe_true), 36'h1);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // =====
  // Scenarios
  task automatic t_lock();
    loop_bypass_n = 1'b1;
    for (int n = 0; n < 400 && loop_locked !== 1'b1; n++) clk_n(1);
    chk(36'(loop_locked), 36'h1);
    $display("lock done");
  endtask
  task automatic t_rw();
    xfer(0, 1, 6'h00, 6'h05, D0, D1, 4'h0, 4'h0);
    xfer(1, 0, 6'h05, 6'h00, D2, D3, 4'hF, 4'hF);
    rd_chk(D0, D1);
    xfer(0, 1, 6'h00, 6'h09, P0, P1, 4'h0, 4'h0);
    xfer(1, 1, 6'h05, 6'h09, D2, D3, 4'hE, 4'h7);
    rd_chk(D0, D1);
    xfer(1, 0, 6'h09, 6'h00, D0, D1, 4'hF, 4'hF);
    rd_chk({P0[35:9], D2[8:0]}, {D3[35:27], P1[26:0]});
    $display("read write done");
  endtask
  task automatic t_nop();
    xfer(0, 0, 6'h09, 6'h09, D0, D1, 4'h0, 4'h0);
    chk(36'(data_out_oe), 36'h0);
    xfer(1, 0, 6'h09, 6'h00, D0, D1, 4'hF, 4'hF);
    rd_chk({P0[35:9], D2[8:0]}, {D3[35:27], P1[26:0]});
    $display("nop done");
  endtask
  task automatic t_tied();
    tie_out = 1'b1;
    xfer(1, 0, 6'h05, 6'h00, D2, D3, 4'hF, 4'hF);
    rd_chk(D0, D1);
    tie_out = 1'b0;
    // Nothing is accessed after bypass, so no idle span is owed.
    loop_bypass_n = 1'b0;
    clk_n(6);
    chk(36'(loop_locked), 36'h0);
    $display("tied and bypass done");
  endtask
  initial begin
    #1 rstn = 1'b0;
    clk_n(3);
    rstn = 1'b1;
    clk_n(2);
    chk(36'(data_out_oe), 36'h0);
    run = 1'b1;
    t_lock();
    t_rw();
    t_nop();
    t_tied();
    end_sim();
  end
  initial begin
    #20000;
    mismatches++;
    end_sim();
  end
endmodule // sbs_port_tb
`default_nettype wire
